/* File: bench/ufl_ctrl_tb.sv */
// self-checking bench for the serial port control block
// assumes the remote model shares the clock; divisor set to 4 gives 4-cycle bits
`timescale 1ns/100ps
`default_nettype none
`include "ufl_params.svh"
module ufl_ctrl_tb;
	localparam int DIV     = 4;
	localparam int LIMIT   = 20000;
	localparam int TRIG[4] = '{1, 4, 8, 14};
	logic        clock_i, rstn_i, wr_i, rd_i, rxd_i, txd_o, rxav, irq_o, rp, rok;
	logic [31:0] addr_i;
	logic [7:0]  wdata_i, rdata_o, d, lcr, rd_d;
	logic [7:0]  q[$];
	int          err_total, checked, cyc, n;

	ufl_ctrl u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .rx_data_available_irq_o(rxav),
		.irq_o(irq_o));
	ufl_remote #(.BIT_CLKS(DIV)) u_remote (.clock_i(clock_i), .txd_i(txd_o), .rxd_o(rxd_i));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// odd, even, stick one, stick zero over the low n bits
	function automatic logic exp_par(input logic [7:0] v, input int w, input logic [1:0] ps);
		logic o;
		o = ^(v & (8'hff >> (8 - w)));
		case (ps)
			2'b00: return ~o;
			2'b01: return o;
			2'b10: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk1(input logic g, input logic e);
		chk({7'h0, g}, {7'h0, e});
	endtask

	task automatic final_report();
		$display("checks=%0d errors=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one-cycle write strobe; the strobe drops at the edge that takes it
	task automatic wr(input logic [31:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe, so look there
	task automatic rd(input logic [31:0] a, input logic [7:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask

	// a hung handshake ends the run here rather than never
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		{rstn_i, wr_i, rd_i, addr_i, wdata_i, cyc, err_total, checked} = '0;
		repeat (3) @(posedge clock_i);
		rstn_i <= 1'b1;
		n = $urandom(13980);
		rd(`UFL_A_LCR, 8'h00);
		rd(`UFL_A_FCR, 8'h01);
		rd(32'he000c020, 8'h00);
		chk1(txd_o, 1'b1);
		wr(`UFL_A_LCR, 8'h80);
		wr(`UFL_A_DATA, 8'(DIV));
		wr(`UFL_A_DIVHI, 8'h00);
		rd(`UFL_A_DATA, 8'(DIV));
		wr(`UFL_A_LCR, 8'h00);
		wr(`UFL_A_FCR, 8'h01);
		rd(`UFL_A_FCR, 8'hc1);
		// every length and parity code first, then random formats
		for (int i = 0; i < 20; i++) begin
			// stop select follows a parity bit so 5-bit words also meet the 1.5 stop length
			lcr = (i < 16) ? {2'b00, i[3:2], 1'b1, i[2], i[1:0]} : 8'($urandom % 64);
			d   = 8'($urandom);
			n   = 5 + int'(lcr[1:0]);
			wr(`UFL_A_LCR, lcr);
			wr(`UFL_A_DATA, d);
			u_remote.recv(n, lcr[3], rd_d, rp, rok);
			chk(rd_d, d & (8'hff >> (8 - n)));
			if (lcr[3]) chk1(rp, exp_par(d, n, lcr[5:4]));
			chk1(rok, 1'b1);
			repeat (12) @(posedge clock_i);
		end
		wr(`UFL_A_LCR, 8'h43);
		repeat (2) @(posedge clock_i);
		#1 chk1(txd_o, 1'b0);
		wr(`UFL_A_LCR, 8'h1b);
		repeat (2) @(posedge clock_i);
		#1 chk1(txd_o, 1'b1);
		// fill up to each trigger level; one short must stay quiet
		for (int t = 0; t < 4; t++) begin
			wr(`UFL_A_FCR, 8'(t << 6) | 8'h03);
			q.delete();
			for (int k = 0; k < TRIG[t]; k++) begin
				if (k == TRIG[t] - 1) begin
					repeat (4) @(posedge clock_i);
					#1 chk1(rxav, 1'b0);
				end
				d = 8'($urandom);
				q.push_back(d);
				u_remote.send(d, 8, 1'b1, exp_par(d, 8, 2'b01));
			end
			repeat (6) @(posedge clock_i);
			#1 chk1(rxav, 1'b1);
		end
		rd(`UFL_A_DATA, q[0]);
		chk1(rxav, 1'b0);
		rd(`UFL_A_LEVEL, 8'h06);
		wr(`UFL_A_FCR, 8'hc1);
		rd(`UFL_A_LEVEL, 8'h06);
		wr(`UFL_A_MASK, 8'h01);
		#1 chk1(irq_o, 1'b1);
		wr(`UFL_A_MASK, 8'h00);
		#1 chk1(irq_o, 1'b0);
		wr(`UFL_A_FCR, 8'hc3);
		rd(`UFL_A_LEVEL, 8'h00);
		wr(`UFL_A_STAT, 8'hff);
		rd(`UFL_A_STAT, 8'h00);
		// an enable change must flush what the fifo holds
		for (int k = 0; k < 2; k++) u_remote.send(8'h5a, 8, 1'b1, 1'b0);
		repeat (6) @(posedge clock_i);
		rd(`UFL_A_LEVEL, 8'h01);
		wr(`UFL_A_FCR, 8'h00);
		rd(`UFL_A_LEVEL, 8'h00);
		rd(`UFL_A_FCR, 8'h01);
		// wrong parity on purpose must raise the parity error status
		u_remote.send(8'h5a, 8, 1'b1, 1'b1);
		repeat (6) @(posedge clock_i);
		rd(`UFL_A_STAT, 8'h03);
		wr(`UFL_A_MASK, 8'h02);
		#1 chk1(irq_o, 1'b1);
		wr(`UFL_A_STAT, 8'h02);
		#1 chk1(irq_o, 1'b0);
		// enable rising flushes the held character; then queue behind a busy
		// transmitter and drop the queue with the tx reset bit
		wr(`UFL_A_FCR, 8'h01);
		rd(`UFL_A_LEVEL, 8'h00);
		for (int k = 0; k < 3; k++) wr(`UFL_A_DATA, 8'($urandom));
		rd(`UFL_A_LEVEL, 8'h10);
		wr(`UFL_A_FCR, 8'h05);
		rd(`UFL_A_LEVEL, 8'h00);
		final_report();
	end
endmodule
`default_nettype wire

/* File: bench/ufl_remote.sv */
// remote serial transceiver model facing the control block's line pins
// assumes the block's clock and a bit time fixed in whole clock cycles
`timescale 1ns/100ps
`default_nettype none
module ufl_remote #(
	parameter int BIT_CLKS = 4
) (
	input  wire logic clock_i,
	input  wire logic txd_i,
	output var  logic rxd_o
);
	// the receive line idles high between frames
	initial rxd_o = 1'b1;

	// one bit time on the line, entered at a rising edge
	task automatic put(input logic b);
		rxd_o <= b;
		repeat (BIT_CLKS) @(posedge clock_i);
	endtask

	// start, data lsb first, parity as commanded (may be wrong on purpose), one stop
	task automatic send(input logic [7:0] d, input int n, input logic pen, input logic pb);
		@(posedge clock_i);
		put(1'b0);
		for (int i = 0; i < n; i++) put(d[i]);
		if (pen) put(pb);
		put(1'b1);
	endtask

	// decode one frame from the block, sampling every bit at its middle
	task automatic recv(input int n, input logic pen, output logic [7:0] d, output logic pb, output logic ok);
		int k;
		d  = 8'h00;
		pb = 1'b0;
		k  = 0;
		// bounded wait for the start edge so a silent line cannot hang the run
		while (txd_i !== 1'b0 && k < 2000) begin
			@(posedge clock_i);
			k++;
		end
		repeat (BIT_CLKS / 2) @(posedge clock_i);
		ok = (txd_i === 1'b0);
		for (int i = 0; i < n; i++) begin
			repeat (BIT_CLKS) @(posedge clock_i);
			d[i] = txd_i;
		end
		if (pen) begin
			repeat (BIT_CLKS) @(posedge clock_i);
			pb = txd_i;
		end
		repeat (BIT_CLKS) @(posedge clock_i);
		ok = ok & (txd_i === 1'b1);
	endtask
endmodule
`default_nettype wire

/* File: hw/ufl_ctrl.sv */
// serial port with fifo control and line format registers
// assumes the register port master of the same clock; rxd_i is asynchronous
//
// How it works
// - fifo enable bit gates upper control bits
// - enable bit change flushes both fifos
// - rx reset bit flushes rx fifo
// - tx reset bit flushes tx fifo
// - writing zero reset bits changes nothing
// - trigger code selects 1, 4, 8, 14
// - word length code selects 5..8 bits
// - parity enable adds and checks parity bit
// - select 00 odd, 01 even parity
// - select 10 forces one, 11 zero
// - break bit holds transmit line low
// - latch access bit opens divisor registers
// - data interrupt follows fill versus trigger, any fill with fifos off
// - identification bits 7:6 mirror enable
`timescale 1ns/100ps
`default_nettype none
`include "ufl_params.svh"
module ufl_ctrl import ufl_pkg::*; (
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        rxd_i,
	output logic             txd_o,
	output logic             rx_data_available_irq_o,
	output logic             irq_o
);
	logic          fe_q, rxs1_q, rxs2_q, txd_q, tx_ph_q, rx_ph_q;
	logic [1:0]    trig_q;
	logic [7:0]    lcr_q, rdata_q, tx_sh_q, rx_sh_q;
	logic [4:0]    st_q, mask_q, st_set;
	logic [15:0]   div_q, half, tx_tmr_q, rx_tmr_q;
	logic [2:0]    tx_bit_q, rx_bit_q, stop_left_q;
	logic          tx_par_q;
	ufl_st_t       tx_st_q, rx_st_q;
	logic [7:0]    rx_mem_q [16];
	logic [7:0]    tx_mem_q [16];
	logic [3:0]    rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
	logic [4:0]    rx_cnt_q, tx_cnt_q, cap, trig;
	logic          div_acc, w_fcr, fe_flip, rx_flush, tx_flush;
	logic          rx_push, rx_pop, tx_push, tx_pop, tx_tick, rx_tick;
	logic [7:0]    rx_word;
	logic [2:0]    wl_top;

	// parity bit for a character under the current format
	function automatic logic par_of(input logic [7:0] d, input logic [7:0] lcr);
		logic [7:0] m;
		m = d & (8'hff >> (2'h3 - lcr[1:0]));
		case (lcr[5:4])
			2'h0:    par_of = ~(^m);
			2'h1:    par_of = ^m;
			2'h2:    par_of = 1'b1;
			default: par_of = 1'b0;
		endcase
	endfunction

	// trigger level decode, compared with the receive fill for the data interrupt
	function automatic logic [4:0] trig_of(input logic [1:0] c);
		case (c)
			2'h0:    trig_of = `UFL_TRIG0;
			2'h1:    trig_of = `UFL_TRIG1;
			2'h2:    trig_of = `UFL_TRIG2;
			default: trig_of = `UFL_TRIG3;
		endcase
	endfunction

	// decode of the register port
	assign div_acc  = lcr_q[`UFL_LCR_DIV];
	assign w_fcr    = wr_i && addr_i == `UFL_A_FCR;
	assign fe_flip  = w_fcr && wdata_i[`UFL_FCR_EN] != fe_q;
	assign rx_flush = fe_flip || (w_fcr && wdata_i[`UFL_FCR_EN] && wdata_i[`UFL_FCR_RXR]);
	assign tx_flush = fe_flip || (w_fcr && wdata_i[`UFL_FCR_EN] && wdata_i[`UFL_FCR_TXR]);
	assign trig     = trig_of(trig_q);
	// with fifos off each side holds one character only
	assign cap      = fe_q ? `UFL_DEPTH : 5'h01;
	assign tx_push  = wr_i && addr_i == `UFL_A_DATA && !div_acc && tx_cnt_q < cap;
	assign rx_pop   = rd_i && addr_i == `UFL_A_DATA && !div_acc && rx_cnt_q != 5'h00;
	assign half     = (div_q >> 1) == 16'h0000 ? 16'h0001 : div_q >> 1;
	assign tx_tick  = tx_tmr_q == 16'h0000;
	assign rx_tick  = rx_tmr_q == 16'h0000;
	assign wl_top   = {1'b1, lcr_q[1:0]};
	assign rx_word  = rx_sh_q >> (3'h3 - {1'b0, lcr_q[1:0]});
	assign rx_data_available_irq_o = fe_q ? rx_cnt_q >= trig : rx_cnt_q != 5'h00;
	assign irq_o    = |(st_q & mask_q);

	// control registers; the enable bit is written on every fifo control write
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			fe_q   <= 1'b0;
			trig_q <= 2'h0;
			lcr_q  <= `UFL_LCR_RST;
			div_q  <= `UFL_DIV_RST;
			mask_q <= 5'h00;
		end else if (wr_i) begin
			if (addr_i == `UFL_A_FCR) begin
				fe_q <= wdata_i[`UFL_FCR_EN];
				if (wdata_i[`UFL_FCR_EN]) begin
					trig_q <= wdata_i[7:6];
				end
			end
			if (addr_i == `UFL_A_LCR) begin
				lcr_q <= wdata_i;
			end
			if (addr_i == `UFL_A_DATA && div_acc) begin
				div_q[7:0] <= wdata_i;
			end
			if (addr_i == `UFL_A_DIVHI && div_acc) begin
				div_q[15:8] <= wdata_i;
			end
			if (addr_i == `UFL_A_MASK) begin
				mask_q <= wdata_i[4:0];
			end
		end
	end

	// read data stand one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`UFL_A_DATA:  rdata_q <= div_acc ? div_q[7:0] : rx_mem_q[rx_rp_q];
				`UFL_A_DIVHI: rdata_q <= div_acc ? div_q[15:8] : 8'h00;
				`UFL_A_FCR:   rdata_q <= {fe_q, fe_q, 2'h0, rx_data_available_irq_o ? 4'h4 : 4'h1};
				`UFL_A_LCR:   rdata_q <= lcr_q;
				`UFL_A_STAT:  rdata_q <= {3'h0, st_q};
				`UFL_A_MASK:  rdata_q <= {3'h0, mask_q};
				`UFL_A_LEVEL: rdata_q <= {tx_cnt_q[4:1], rx_cnt_q[4:1]};
				default:      rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign rdata_o = rdata_q;

	// sticky status: 0 data available, 1 parity, 2 framing, 3 overrun, 4 tx empty
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			st_q <= 5'h00;
		end else if (wr_i && addr_i == `UFL_A_STAT) begin
			st_q <= (st_q & ~wdata_i[4:0]) | st_set; // set wins over clear
		end else begin
			st_q <= st_q | st_set;
		end
	end

	// receive fifo storage; a flush only moves pointers
	always_ff @(posedge clock_i) begin
		if (!rstn_i || rx_flush) begin
			rx_wp_q  <= 4'h0;
			rx_rp_q  <= 4'h0;
			rx_cnt_q <= 5'h00;
		end else begin
			if (rx_push) begin
				rx_mem_q[rx_wp_q] <= rx_word;
				rx_wp_q           <= rx_wp_q + 4'h1;
			end
			if (rx_pop) begin
				rx_rp_q <= rx_rp_q + 4'h1;
			end
			rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
		end
	end

	// transmit fifo storage; writes to a full fifo are dropped
	always_ff @(posedge clock_i) begin
		if (!rstn_i || tx_flush) begin
			tx_wp_q  <= 4'h0;
			tx_rp_q  <= 4'h0;
			tx_cnt_q <= 5'h00;
		end else begin
			if (tx_push) begin
				tx_mem_q[tx_wp_q] <= wdata_i;
				tx_wp_q           <= tx_wp_q + 4'h1;
			end
			if (tx_pop) begin
				tx_rp_q <= tx_rp_q + 4'h1;
			end
			tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
		end
	end

	// half-bit timers; half bits give the 1.5 stop length cheaply
	always_ff @(posedge clock_i) begin
		if (!rstn_i || tx_st_q == ST_IDLE || tx_tick) begin
			tx_tmr_q <= half - 16'h0001;
		end else begin
			tx_tmr_q <= tx_tmr_q - 16'h0001;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rstn_i || rx_st_q == ST_IDLE || rx_tick) begin
			rx_tmr_q <= half - 16'h0001;
		end else begin
			rx_tmr_q <= rx_tmr_q - 16'h0001;
		end
	end

	// transmitter
	assign tx_pop = tx_st_q == ST_IDLE && tx_cnt_q != 5'h00 && !tx_flush;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			tx_st_q     <= ST_IDLE;
			tx_sh_q     <= 8'h00;
			tx_par_q    <= 1'b0;
			tx_ph_q     <= 1'b0;
			tx_bit_q    <= 3'h0;
			stop_left_q <= 3'h0;
		end else begin
			case (tx_st_q)
				ST_IDLE: begin
					if (tx_pop) begin
						tx_sh_q  <= tx_mem_q[tx_rp_q];
						tx_par_q <= par_of(tx_mem_q[tx_rp_q], lcr_q);
						tx_ph_q  <= 1'b0;
						tx_bit_q <= 3'h0;
						tx_st_q  <= ST_START;
					end
				end
				ST_START: begin
					if (tx_tick) begin
						tx_ph_q <= ~tx_ph_q;
						if (tx_ph_q) begin
							tx_st_q <= ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (tx_tick) begin
						tx_ph_q <= ~tx_ph_q;
						if (tx_ph_q) begin
							tx_sh_q  <= tx_sh_q >> 1;
							tx_bit_q <= tx_bit_q + 3'h1;
							if (tx_bit_q == wl_top) begin
								tx_st_q     <= lcr_q[`UFL_LCR_PEN] ? ST_PAR : ST_STOP;
								stop_left_q <= !lcr_q[`UFL_LCR_SB] ? 3'h2 : (lcr_q[1:0] == 2'h0 ? 3'h3 : 3'h4);
							end
						end
					end
				end
				ST_PAR: begin
					if (tx_tick) begin
						tx_ph_q <= ~tx_ph_q;
						if (tx_ph_q) begin
							tx_st_q <= ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (tx_tick) begin
						stop_left_q <= stop_left_q - 3'h1;
						if (stop_left_q == 3'h1) begin
							tx_st_q <= ST_IDLE;
						end
					end
				end
				default: tx_st_q <= ST_IDLE;
			endcase
		end
	end

	// line level from a flop; break overrides everything
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			txd_q <= 1'b1;
		end else if (lcr_q[`UFL_LCR_BRK]) begin
			txd_q <= 1'b0;
		end else begin
			case (tx_st_q)
				ST_START: txd_q <= 1'b0;
				ST_DATA:  txd_q <= tx_sh_q[0];
				ST_PAR:   txd_q <= tx_par_q;
				default:  txd_q <= 1'b1;
			endcase
		end
	end
	assign txd_o = txd_q;

	// two-flop synchroniser on the receive pin
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rxs1_q <= 1'b1;
			rxs2_q <= 1'b1;
		end else begin
			rxs1_q <= rxd_i;
			rxs2_q <= rxs1_q;
		end
	end

	// receiver samples mid-bit: one half bit after the edge, then every full bit
	assign rx_push = rx_st_q == ST_STOP && rx_tick && rx_ph_q && rx_cnt_q < cap && !rx_flush;
	assign st_set  = {tx_pop && tx_cnt_q == 5'h01,
		rx_st_q == ST_STOP && rx_tick && rx_ph_q && !rx_push,
		rx_st_q == ST_STOP && rx_tick && rx_ph_q && !rxs2_q,
		rx_st_q == ST_PAR && rx_tick && rx_ph_q && rxs2_q != par_of(rx_word, lcr_q),
		rx_data_available_irq_o};
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			rx_st_q  <= ST_IDLE;
			rx_sh_q  <= 8'h00;
			rx_ph_q  <= 1'b0;
			rx_bit_q <= 3'h0;
		end else begin
			case (rx_st_q)
				ST_IDLE: begin
					if (!rxs2_q) begin
						rx_st_q  <= ST_START;
						rx_bit_q <= 3'h0;
					end
				end
				ST_START: begin
					if (rx_tick) begin
						rx_ph_q <= 1'b0;
						rx_st_q <= rxs2_q ? ST_IDLE : ST_DATA; // glitch rejected
					end
				end
				ST_DATA: begin
					if (rx_tick) begin
						rx_ph_q <= ~rx_ph_q;
						if (rx_ph_q) begin
							rx_sh_q  <= {rxs2_q, rx_sh_q[7:1]};
							rx_bit_q <= rx_bit_q + 3'h1;
							if (rx_bit_q == wl_top) begin
								rx_st_q <= lcr_q[`UFL_LCR_PEN] ? ST_PAR : ST_STOP;
							end
						end
					end
				end
				ST_PAR: begin
					if (rx_tick) begin
						rx_ph_q <= ~rx_ph_q;
						if (rx_ph_q) begin
							rx_st_q <= ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (rx_tick) begin
						rx_ph_q <= ~rx_ph_q;
						if (rx_ph_q) begin
							rx_st_q <= ST_IDLE;
						end
					end
				end
				default: rx_st_q <= ST_IDLE;
			endcase
		end
	end

	// checks
	AST_FE_FLUSH: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$changed(fe_q) |-> rx_cnt_q == 5'h00 && tx_cnt_q == 5'h00)
		else $error("enable change did not flush");
	AST_RX_FLUSH: assert property (@(posedge clock_i) disable iff (!rstn_i)
		w_fcr && wdata_i[1:0] == 2'h3 |=> rx_cnt_q == 5'h00)
		else $error("rx flush failed");
	AST_TX_FLUSH: assert property (@(posedge clock_i) disable iff (!rstn_i)
		w_fcr && wdata_i[`UFL_FCR_EN] && wdata_i[`UFL_FCR_TXR] |=> tx_cnt_q == 5'h00)
		else $error("tx flush failed");
	AST_FCR_GATE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		w_fcr && !wdata_i[`UFL_FCR_EN] |=> $stable(trig_q))
		else $error("trigger written while disabled");
	AST_RXAV_RISE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(rx_data_available_irq_o) && fe_q |-> rx_cnt_q == trig)
		else $error("data interrupt off trigger level");
	AST_ID_MIRROR: assert property (@(posedge clock_i) disable iff (!rstn_i)
		rd_i && addr_i == `UFL_A_FCR |=> rdata_o[7:6] == {2{$past(fe_q)}})
		else $error("id bits do not mirror enable");
	AST_BREAK: assert property (@(posedge clock_i) disable iff (!rstn_i)
		lcr_q[`UFL_LCR_BRK] |=> !txd_o)
		else $error("break not on line");
	AST_START_LOW: assert property (@(posedge clock_i) disable iff (!rstn_i)
		tx_st_q == ST_START |=> !txd_o)
		else $error("start bit not low");
	AST_STOP_HIGH: assert property (@(posedge clock_i) disable iff (!rstn_i)
		tx_st_q == ST_STOP && !lcr_q[`UFL_LCR_BRK] |=> txd_o)
		else $error("stop bit not high");
	AST_STICK_ONE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		tx_st_q == ST_PAR && lcr_q[5:4] == 2'h2 && !lcr_q[`UFL_LCR_BRK] |=> txd_o)
		else $error("stick one parity wrong");
	AST_STOP_LEN: assert property (@(posedge clock_i) disable iff (!rstn_i)
		tx_st_q == ST_STOP && $past(tx_st_q) != ST_STOP && lcr_q[`UFL_LCR_SB] && lcr_q[1:0] == 2'h0
		|-> stop_left_q == 3'h3)
		else $error("short stop length wrong");
	AST_RESET_ZERO: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(rstn_i) |-> lcr_q == 8'h00 && !fe_q)
		else $error("control not zero after reset");
	COV_BREAK: cover property (@(posedge clock_i) disable iff (!rstn_i) lcr_q[`UFL_LCR_BRK] ##1 !txd_o);
	COV_RXAV: cover property (@(posedge clock_i) disable iff (!rstn_i) $rose(rx_data_available_irq_o) && trig_q == 2'h3);
	COV_HALF_STOP: cover property (@(posedge clock_i) disable iff (!rstn_i) tx_st_q == ST_STOP && stop_left_q == 3'h3);
endmodule
`default_nettype wire

/* File: hw/ufl_params.svh */
// offsets, field positions, reset values and counts for the serial port control block
// assumes a 32-bit byte address from the register port
`ifndef UFL_PARAMS_SVH
`define UFL_PARAMS_SVH
`define UFL_A_DATA   32'he000c000
`define UFL_A_DIVHI  32'he000c004
`define UFL_A_FCR    32'he000c008
`define UFL_A_LCR    32'he000c00c
`define UFL_A_STAT   32'he000c040
`define UFL_A_MASK   32'he000c044
`define UFL_A_LEVEL  32'he000c048
`define UFL_FCR_EN   0
`define UFL_FCR_RXR  1
`define UFL_FCR_TXR  2
`define UFL_LCR_SB   2
`define UFL_LCR_PEN  3
`define UFL_LCR_BRK  6
`define UFL_LCR_DIV  7
`define UFL_LCR_RST  8'h00
`define UFL_DIV_RST  16'h0010
`define UFL_DEPTH    5'h10
`define UFL_TRIG0    5'h01
`define UFL_TRIG1    5'h04
`define UFL_TRIG2    5'h08
`define UFL_TRIG3    5'h0e
`endif

/* File: hw/ufl_pkg.sv */
// types of the serial port control block
// imported by the block only; the bench does not use it
package ufl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_DATA  = 3'b010,
		ST_PAR   = 3'b011,
		ST_STOP  = 3'b100
	} ufl_st_t;
endpackage
